// *** design/sfsr_pkg.sv ***
package sfsr_pkg;

    // Command opcodes
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ_LOW = 8'h05;
    localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_BUSY_MONITOR = 8'h25;
    localparam logic [7:0] OP_STATUS_READ_HIGH = 8'h35;
    localparam logic [7:0] OP_SUSPEND_A = 8'h75;
    localparam logic [7:0] OP_SUSPEND_B = 8'hb0;
    localparam logic [7:0] OP_RESUME_A = 8'h7a;
    localparam logic [7:0] OP_RESUME_B = 8'h30;
    localparam logic [7:0] OP_RESET = 8'h99;

    // Bit positions in flash_status_word
    localparam int BUSY_BIT = 0;
    localparam int WRITE_LATCH_BIT = 1;
    localparam int GUARD_LSB = 2;
    localparam int GUARD_MSB = 6;
    localparam int PROTECT_MODE_LOW_BIT = 7;
    localparam int PROTECT_MODE_HIGH_BIT = 8;
    localparam int QUAD_LANE_BIT = 9;
    localparam int PROGRAM_SUSPENDED_BIT = 10;
    localparam int LOCK_LSB = 11;
    localparam int LOCK_MSB = 13;
    localparam int PROTECT_COMPLEMENT_BIT = 14;
    localparam int ERASE_SUSPENDED_BIT = 15;

    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // Bits a status write never touches
    localparam logic [15:0] KEEP_MASK = 16'h8403;
    // Bits cleared by a one-byte status write
    localparam logic [15:0] SHORT_WRITE_CLEAR_MASK = 16'h4300;
    localparam logic [15:0] LOCK_MASK = 16'h3800;

    // Protection modes, high bit first
    localparam logic [1:0] PM_SOFTWARE = 2'b00;
    localparam logic [1:0] PM_HARDWARE = 2'b01;
    localparam logic [1:0] PM_LOCKDOWN = 2'b10;
    localparam logic [1:0] PM_ONE_TIME = 2'b11;

    // Frame bit counting
    localparam logic [5:0] BIT_CNT_MAX = 6'h3f;
    localparam logic [5:0] BIT_OPCODE_LAST = 6'h07;
    localparam logic [5:0] BIT_ADDR_LAST = 6'h1f;
    localparam logic [5:0] BIT_DUMMY_LAST = 6'h27;
    localparam logic [5:0] BITS_SINGLE_CMD = 6'h08;
    localparam logic [5:0] BITS_STATUS_SHORT = 6'h10;
    localparam logic [5:0] BITS_STATUS_LONG = 6'h18;

    // Timing
    localparam int CLOCK_MHZ = 50;
    localparam int STATUS_WRITE_CYCLE_TIME_US = 5000;
    localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_CYCLE_TIME_US * CLOCK_MHZ;

    typedef enum logic [1:0] {
        WS_IDLE = 2'b01,
        WS_WRITING = 2'b10
    } sfsr_wstate_e;

endpackage

// *** design/sfsr_array.sv ***
`timescale 1ns/100ps
`default_nettype none

// Byte array; written on the core clock, read combinationally from the link side
module sfsr_array #(
    parameter int AW = 16,
    parameter int DW = 8
) (
    input wire logic wr_clock_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Preload only while no read frame is active; the ports share no clock
    always_ff @(posedge wr_clock_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem[rd_addr_i];

endmodule

`default_nettype wire

// *** design/sfsr_top.sv ***
// Summary of operation
// R1 - Mode 00: status write needs latch only
// R2 - Mode 01, protect pin low: refuse writes
// R3 - Mode 01, protect pin high: latch allows
// R4 - Mode 10: locked until power cycle
// R5 - Mode 11: status never writable again
// R6 - Quad enable turns protect pin into data
// R7 - Three security locks, one-time settable
// R8 - Complement bit kept, drives area select
// R9 - Suspend flags set by suspend, resume clears
// R10 - Host sends busy-monitor opcode, mode-3 dummy
// R11 - Busy monitor shows live busy on output
// R12 - Chip select high ends monitor, tristate
// R13 - Status write requires prior latch set
// R14 - Status write keeps S15, S10, S1, S0
// R15 - Status write only at 8/16 bits
// R16 - One-byte write clears complement, quad, high mode
// R17 - Self-timed write cycle, busy, then latch clear
// R18 - No status write under hardware protection
// R19 - Plain read: opcode, address, data out
// R20 - Reads auto-increment address and wrap
// R21 - Fast read needs one dummy byte
// R22 - Fast read rejected while busy
// R23 - Busy flag set during write cycles
// R24 - Latch clear blocks status writes
// R25 - Two-byte write: low byte first
// R26 - Security locks never clear
`timescale 1ns/100ps
`default_nettype none

module sfsr_top #(
    parameter int ARRAY_AW = 16,
    parameter int WRITE_CYCLES = sfsr_pkg::STATUS_WRITE_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_n_o,
    input wire logic ext_op_busy_i,
    input wire logic ext_op_is_erase_i,
    input wire logic array_wr_en_i,
    input wire logic [ARRAY_AW-1:0] array_wr_addr_i,
    input wire logic [7:0] array_wr_data_i,
    output logic busy_o,
    output logic write_latch_o,
    output logic [1:0] protect_mode_o,
    output logic quad_lane_enable_o,
    output logic [4:0] region_guard_o,
    output logic protect_complement_o,
    output logic [2:0] security_lock_o,
    output logic erase_suspended_o,
    output logic program_suspended_o
);

    localparam int WR_CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [WR_CNT_W-1:0] WR_LAST = WR_CNT_W'(WRITE_CYCLES - 1);

    // Link domain: frame state, cleared by chip select high
    logic [5:0] bit_cnt, next_bit_cnt;
    logic data_phase, src_status, sel_high, asi_mode, fast_reject;
    logic [2:0] bitpos;
    logic [ARRAY_AW-1:0] rd_addr;
    // Link domain captures read by the core after the frame ends
    logic [23:0] shift_in;
    logic [7:0] cap_opcode, new_opcode;
    logic [5:0] cap_cnt;
    // Link domain falling-edge outputs
    logic so_shift, asi_out;
    logic [7:0] out_byte, mem_rdata;
    logic busy_meta_sck, busy_sck;

    // Core domain
    logic cs_meta, cs_sync, cs_prev, wp_meta, wp_sync, frame_end;
    logic [15:0] nv = sfsr_pkg::STATUS_RESET;
    logic [15:0] pend_nv, flash_status_word, incoming, composed;
    logic write_latch_flag, busy_flag, erase_sus, prog_sus, hw_protected, mode_allows;
    logic status_write_cmd_start, wr_done, single_cmd;
    logic [1:0] pm;
    logic [WR_CNT_W-1:0] wr_cnt;
    sfsr_pkg::sfsr_wstate_e wstate;

    sfsr_array #(
        .AW(ARRAY_AW),
        .DW(8)
    ) u_array (
        .wr_clock_i(clock_i),
        .wr_en_i(array_wr_en_i),
        .wr_addr_i(array_wr_addr_i),
        .wr_data_i(array_wr_data_i),
        .rd_addr_i(rd_addr),
        .rd_data_o(mem_rdata)
    );

    function automatic logic is_op(input logic [7:0] op, input logic [7:0] a,
                                   input logic [7:0] b);
        is_op = (op == a) || (op == b);
    endfunction

    assign next_bit_cnt = (bit_cnt == sfsr_pkg::BIT_CNT_MAX) ? bit_cnt : bit_cnt + 6'h01;
    assign new_opcode = {shift_in[6:0], si_i};

    // Serial input shifts on rising edges; no reset so it survives the frame end
    always_ff @(posedge sck_i) begin
        shift_in <= {shift_in[22:0], si_i}; // [R19]
        cap_cnt <= next_bit_cnt; // [R15]
        if (bit_cnt == sfsr_pkg::BIT_OPCODE_LAST) begin
            cap_opcode <= new_opcode;
        end
    end

    // Busy level into the link domain; only valid once the host clocks
    always_ff @(posedge sck_i) begin
        busy_meta_sck <= busy_flag;
        busy_sck <= busy_meta_sck;
    end

    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt <= 6'h00;
        end else begin
            bit_cnt <= next_bit_cnt;
        end
    end

    // Command decode and read sequencing
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            data_phase <= 1'b0;
            src_status <= 1'b0;
            sel_high <= 1'b0;
            asi_mode <= 1'b0;
            fast_reject <= 1'b0;
        end else if (bit_cnt == sfsr_pkg::BIT_OPCODE_LAST) begin
            if (is_op(new_opcode, sfsr_pkg::OP_STATUS_READ_LOW,
                      sfsr_pkg::OP_STATUS_READ_HIGH)) begin
                data_phase <= 1'b1;
                src_status <= 1'b1;
                sel_high <= (new_opcode == sfsr_pkg::OP_STATUS_READ_HIGH);
            end
            asi_mode <= (new_opcode == sfsr_pkg::OP_BUSY_MONITOR); // [R11]
            fast_reject <= busy_sck; // [R22]
        end else if (bit_cnt == sfsr_pkg::BIT_ADDR_LAST &&
                     cap_opcode == sfsr_pkg::OP_READ) begin
            data_phase <= 1'b1; // [R19]
        end else if (bit_cnt == sfsr_pkg::BIT_DUMMY_LAST &&
                     cap_opcode == sfsr_pkg::OP_FAST_READ) begin
            data_phase <= ~fast_reject; // [R21] [R22]
        end
    end

    // Address latch and advance; the counter is only ARRAY_AW wide so it wraps
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bitpos <= 3'h0;
            rd_addr <= '0;
        end else if (bit_cnt == sfsr_pkg::BIT_ADDR_LAST) begin
            rd_addr <= {shift_in[ARRAY_AW-2:0], si_i}; // [R19]
            bitpos <= 3'h0;
        end else if (data_phase) begin
            bitpos <= bitpos + 3'h1;
            if (bitpos == 3'h7 && !src_status) begin
                rd_addr <= rd_addr + ARRAY_AW'(1); // [R20]
            end
        end
    end

    // Status bits other than busy are read as is, unsynchronised; nv and the latch can change mid-frame when a write cycle ends
    always_comb begin
        if (src_status) begin
            if (sel_high) begin
                out_byte = flash_status_word[15:8];
            end else begin
                out_byte = {flash_status_word[7:1], busy_sck};
            end
        end else begin
            out_byte = mem_rdata;
        end
    end

    // Output shifts on falling edges
    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_shift <= 1'b0;
            so_oe_n_o <= 1'b1; // [R12]
            asi_out <= 1'b0; // [R12]
        end else begin
            so_shift <= out_byte[3'h7 - bitpos]; // [R19]
            so_oe_n_o <= ~(data_phase | asi_mode);
            asi_out <= asi_mode; // [R10]
        end
    end

    // Monitor output follows the core busy flop with no clock on the link
    assign so_o = asi_out ? busy_flag : so_shift; // [R11]

    // Core: chip select and protect pin synchronisers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            wp_meta <= 1'b1;
            wp_sync <= 1'b1;
        end else begin
            cs_meta <= cs_n_i;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            wp_meta <= wp_n_i;
            wp_sync <= wp_meta;
        end
    end

    // Captured frame is stable while chip select is high and the link idles
    assign frame_end = cs_sync & ~cs_prev;
    assign single_cmd = frame_end && cap_cnt == sfsr_pkg::BITS_SINGLE_CMD;
    assign pm = {nv[sfsr_pkg::PROTECT_MODE_HIGH_BIT], nv[sfsr_pkg::PROTECT_MODE_LOW_BIT]};

    // Protect pin counts only while it is not a data lane
    assign hw_protected = (pm == sfsr_pkg::PM_HARDWARE) && !wp_sync &&
                          !nv[sfsr_pkg::QUAD_LANE_BIT]; // [R2] [R6]

    always_comb begin
        case (pm)
            sfsr_pkg::PM_SOFTWARE: mode_allows = 1'b1; // [R1]
            sfsr_pkg::PM_HARDWARE: mode_allows = !hw_protected; // [R3] [R18]
            sfsr_pkg::PM_LOCKDOWN: mode_allows = 1'b0; // [R4]
            sfsr_pkg::PM_ONE_TIME: mode_allows = 1'b0; // [R5]
            default: mode_allows = 1'b0;
        endcase
    end

    assign status_write_cmd_start = frame_end && cap_opcode == sfsr_pkg::OP_STATUS_WRITE &&
                        (cap_cnt == sfsr_pkg::BITS_STATUS_SHORT ||
                         cap_cnt == sfsr_pkg::BITS_STATUS_LONG) && // [R15]
                        write_latch_flag && !busy_flag && mode_allows && // [R13] [R24]
                        wstate == sfsr_pkg::WS_IDLE;

    // First data byte is S7..S0, second S15..S8
    always_comb begin
        if (cap_cnt == sfsr_pkg::BITS_STATUS_LONG) begin
            incoming = {shift_in[7:0], shift_in[15:8]}; // [R25]
        end else begin
            incoming = {nv[15:8] & ~sfsr_pkg::SHORT_WRITE_CLEAR_MASK[15:8],
                        shift_in[7:0]}; // [R16]
        end
        composed = (incoming & ~sfsr_pkg::KEEP_MASK & ~sfsr_pkg::LOCK_MASK) |
                   (nv & sfsr_pkg::KEEP_MASK) | // [R14]
                   ((incoming | nv) & sfsr_pkg::LOCK_MASK); // [R7] [R26]
    end

    // Self-timed status write cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wstate <= sfsr_pkg::WS_IDLE;
            wr_cnt <= '0;
        end else begin
            case (wstate)
                sfsr_pkg::WS_IDLE: begin
                    if (status_write_cmd_start) begin
                        wstate <= sfsr_pkg::WS_WRITING; // [R17]
                        wr_cnt <= '0;
                    end
                end
                sfsr_pkg::WS_WRITING: begin
                    if (wr_cnt == WR_LAST) begin
                        wstate <= sfsr_pkg::WS_IDLE;
                    end else begin
                        wr_cnt <= wr_cnt + WR_CNT_W'(1);
                    end
                end
                default: wstate <= sfsr_pkg::WS_IDLE;
            endcase
        end
    end

    assign wr_done = (wstate == sfsr_pkg::WS_WRITING) && (wr_cnt == WR_LAST);

    // New value staged at start; old value stays readable through the cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pend_nv <= sfsr_pkg::STATUS_RESET;
        end else if (status_write_cmd_start) begin
            pend_nv <= composed;
        end
    end

    // Non-volatile bits survive reset; only the lock-down mode is released
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            if (pm == sfsr_pkg::PM_LOCKDOWN) begin
                nv[sfsr_pkg::PROTECT_MODE_HIGH_BIT] <= 1'b0; // [R4]
                nv[sfsr_pkg::PROTECT_MODE_LOW_BIT] <= 1'b0;
            end
        end else if (wr_done) begin
            nv <= pend_nv; // [R8] [R17]
        end
    end

    // Latch set wins over a clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            write_latch_flag <= 1'b0;
        end else if (single_cmd && cap_opcode == sfsr_pkg::OP_WRITE_LATCH_SET) begin
            write_latch_flag <= 1'b1;
        end else if (wr_done ||
                     (single_cmd && is_op(cap_opcode, sfsr_pkg::OP_WRITE_LATCH_CLR,
                                          sfsr_pkg::OP_RESET))) begin
            write_latch_flag <= 1'b0; // [R17]
        end
    end

    // Suspend flags; a suspend with nothing running is ignored
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            erase_sus <= 1'b0;
            prog_sus <= 1'b0;
        end else if (single_cmd && ext_op_busy_i &&
                     is_op(cap_opcode, sfsr_pkg::OP_SUSPEND_A, sfsr_pkg::OP_SUSPEND_B)) begin
            if (ext_op_is_erase_i) begin
                erase_sus <= 1'b1; // [R9]
            end else begin
                prog_sus <= 1'b1; // [R9]
            end
        end else if (single_cmd &&
                     is_op(cap_opcode, sfsr_pkg::OP_RESUME_A, sfsr_pkg::OP_RESUME_B)) begin
            erase_sus <= 1'b0; // [R9]
            prog_sus <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            busy_flag <= 1'b0;
        end else begin
            busy_flag <= status_write_cmd_start || (wstate == sfsr_pkg::WS_WRITING && !wr_done) ||
                         (ext_op_busy_i && !erase_sus && !prog_sus); // [R23]
        end
    end

    always_comb begin
        flash_status_word = nv & ~sfsr_pkg::KEEP_MASK;
        flash_status_word[sfsr_pkg::ERASE_SUSPENDED_BIT] = erase_sus;
        flash_status_word[sfsr_pkg::PROGRAM_SUSPENDED_BIT] = prog_sus;
        flash_status_word[sfsr_pkg::WRITE_LATCH_BIT] = write_latch_flag;
        flash_status_word[sfsr_pkg::BUSY_BIT] = busy_flag;
    end

    assign busy_o = busy_flag;
    assign write_latch_o = write_latch_flag;
    assign protect_mode_o = pm;
    assign quad_lane_enable_o = nv[sfsr_pkg::QUAD_LANE_BIT]; // [R6]
    assign region_guard_o = nv[sfsr_pkg::GUARD_MSB:sfsr_pkg::GUARD_LSB];
    assign protect_complement_o = nv[sfsr_pkg::PROTECT_COMPLEMENT_BIT]; // [R8]
    assign security_lock_o = nv[sfsr_pkg::LOCK_MSB:sfsr_pkg::LOCK_LSB]; // [R7]
    assign erase_suspended_o = erase_sus;
    assign program_suspended_o = prog_sus;

endmodule

`default_nettype wire

// *** dv/sfsr_top_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none

module sfsr_top_checker #(
    parameter int WRITE_CYCLES = 20
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic ext_op_busy_i,
    input wire logic ext_op_is_erase_i,
    input wire logic so_oe_n_o,
    input wire logic busy_o,
    input wire logic write_latch_o,
    input wire logic [1:0] protect_mode_o,
    input wire logic quad_lane_enable_o,
    input wire logic [4:0] region_guard_o,
    input wire logic protect_complement_o,
    input wire logic [2:0] security_lock_o,
    input wire logic erase_suspended_o,
    input wire logic program_suspended_o
);
    logic [11:0] nv;
    int run;

    assign nv = {protect_complement_o, security_lock_o, quad_lane_enable_o, protect_mode_o,
                 region_guard_o};

    // Engine activity restarts the count, so only the self-timed cycle is measured
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !busy_o || ext_op_busy_i) begin
            run <= 0;
        end else begin
            run <= run + 1;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    busy_len_a: assert property (busy_o |-> run <= WRITE_CYCLES)
        else $error("write cycle too long");
    done_latch_a: assert property ($fell(busy_o) && !$past(ext_op_busy_i)
        && !$past(ext_op_busy_i, 2) |-> !write_latch_o) else $error("latch kept after cycle");
    nv_hold_a: assert property (!$fell(busy_o) |-> $stable(nv))
        else $error("status changed outside cycle end");
    nv_latch_a: assert property ($changed(nv) |-> $past(write_latch_o))
        else $error("status changed without latch");
    lock_set_a: assert property (!(|($past(security_lock_o) & ~security_lock_o)))
        else $error("lock bit cleared");
    locked_mode_a: assert property ($past(protect_mode_o[1]) |-> $stable(nv))
        else $error("locked status changed");
    busy_ext_a: assert property ((ext_op_busy_i && !erase_suspended_o
        && !program_suspended_o) [*2] |-> busy_o) else $error("busy missing");
    erase_sus_a: assert property ($rose(erase_suspended_o) |-> $past(ext_op_busy_i)
        && $past(ext_op_is_erase_i)) else $error("bad erase suspend");
    prog_sus_a: assert property ($rose(program_suspended_o) |-> $past(ext_op_busy_i)
        && !$past(ext_op_is_erase_i)) else $error("bad program suspend");
    so_idle_a: assert property (cs_n_i && $past(cs_n_i) |-> so_oe_n_o)
        else $error("output driven while deselected");
endmodule

bind sfsr_top sfsr_top_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
    .clock_i, .rst_n_i, .cs_n_i, .ext_op_busy_i, .ext_op_is_erase_i, .so_oe_n_o, .busy_o,
    .write_latch_o, .protect_mode_o, .quad_lane_enable_o, .region_guard_o,
    .protect_complement_o, .security_lock_o, .erase_suspended_o, .program_suspended_o
);

`default_nettype wire

// *** dv/sfsr_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module sfsr_host_model (
    input wire logic link_clk_i,
    input wire logic so_i,
    input wire logic so_oe_n_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o
);
    logic en = 1'b0;

    // Early rising edge clears link logic that only chip select resets
    initial begin
        cs_n_o = 1'b0;
        si_o = 1'b0;
        #1 cs_n_o = 1'b1;
    end

    // Mode 0: clock idles low and stands still outside frames
    assign sck_o = link_clk_i & en;

    task automatic frame(input logic [63:0] tx, input int nb, input bit keep,
                         output logic [63:0] rx, output logic drv);
        rx = '0;
        drv = 1'b0;
        // Gap long enough for the core to see the previous frame end
        #100;
        @(negedge link_clk_i) cs_n_o <= 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            @(negedge link_clk_i);
            si_o <= tx[i];
            en <= 1'b1;
            @(posedge link_clk_i);
            rx = {rx[62:0], so_oe_n_i ? ~so_i : so_i};
            drv = drv | !so_oe_n_i;
        end
        @(negedge link_clk_i);
        en <= 1'b0;
        si_o <= ~si_o;
        if (!keep) begin
            end_frame();
        end
    endtask

    task automatic end_frame();
        @(negedge link_clk_i) cs_n_o <= 1'b1;
    endtask
endmodule

`default_nettype wire

// *** dv/serial_flash_status_and_read_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module serial_flash_status_and_read_tb_top;
    typedef struct packed {
        logic wp;
        logic lat;
        logic [4:0] nb;
        logic [15:0] d;
        logic acc;
        logic [15:0] ex;
    } sfsr_row_s;

    // Short cycle keeps the run small; busy windows below rely on it
    localparam int WC = 60;
    logic clock_i = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n_i = 1'b0;
    logic sck_i, cs_n_i, si_i, so_o, so_oe_n_o, busy_o, write_latch_o;
    logic quad_lane_enable_o, protect_complement_o, erase_suspended_o, program_suspended_o;
    logic wp_n_i = 1'b1;
    logic ext_op_busy_i = 1'b0;
    logic ext_op_is_erase_i = 1'b0;
    logic array_wr_en_i = 1'b0;
    logic [15:0] array_wr_addr_i = 16'h0000;
    logic [7:0] array_wr_data_i = 8'h00;
    logic [1:0] protect_mode_o;
    logic [4:0] region_guard_o;
    logic [2:0] security_lock_o;
    logic [63:0] rx;
    logic drv;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    sfsr_row_s rows [10] = '{
        '{1'b1, 1'b1, 5'h10, 16'hce3f, 1'b1, 16'h4a3c},
        '{1'b1, 1'b0, 5'h10, 16'h0000, 1'b0, 16'h4a3c},
        '{1'b1, 1'b1, 5'h0c, 16'h0000, 1'b0, 16'h4a3c},
        '{1'b1, 1'b1, 5'h08, 16'h0000, 1'b1, 16'h0800},
        '{1'b1, 1'b1, 5'h10, 16'h0080, 1'b1, 16'h0880},
        '{1'b0, 1'b1, 5'h10, 16'h0004, 1'b0, 16'h0880},
        '{1'b1, 1'b1, 5'h10, 16'h0280, 1'b1, 16'h0a80},
        '{1'b0, 1'b1, 5'h10, 16'h0284, 1'b1, 16'h0a84},
        '{1'b1, 1'b1, 5'h10, 16'h0104, 1'b1, 16'h0904},
        '{1'b1, 1'b1, 5'h10, 16'h0000, 1'b0, 16'h0904}
    };

    sfsr_top #(.ARRAY_AW(16), .WRITE_CYCLES(WC)) DUT (
        .clock_i, .rst_n_i, .sck_i, .cs_n_i, .si_i, .wp_n_i, .so_o, .so_oe_n_o, .ext_op_busy_i,
        .ext_op_is_erase_i, .array_wr_en_i, .array_wr_addr_i, .array_wr_data_i, .busy_o,
        .write_latch_o, .protect_mode_o, .quad_lane_enable_o, .region_guard_o,
        .protect_complement_o, .security_lock_o, .erase_suspended_o, .program_suspended_o
    );

    sfsr_host_model host (.link_clk_i(link_clk), .so_i(so_o), .so_oe_n_i(so_oe_n_o),
                          .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i));

    initial begin
        forever #10 clock_i = ~clock_i;
    end

    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check_word(input logic [15:0] g, input logic [15:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: %s got %h", $time, m, g);
        end
    endtask

    task automatic check_bit(input logic g, input logic e, input string m);
        check_word({15'h0000, g}, {15'h0000, e}, m);
    endtask

    function automatic logic [15:0] st();
        return {erase_suspended_o, protect_complement_o, security_lock_o, program_suspended_o,
                quad_lane_enable_o, protect_mode_o, region_guard_o, write_latch_o, busy_o};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic send(input logic [63:0] tx, input int nb);
        host.frame(tx, nb, 1'b0, rx, drv);
    endtask

    task automatic do_reset();
        @(posedge clock_i) rst_n_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        tick(4);
    endtask

    task automatic step(input sfsr_row_s r);
        logic [23:0] w;
        int n;
        n = 0;
        w = {sfsr_pkg::OP_STATUS_WRITE, r.d[7:0], r.d[15:8]};
        // Protect pin passes a two-stage sync
        @(posedge clock_i) wp_n_i <= r.wp;
        tick(4);
        if (r.lat) send({56'h0, sfsr_pkg::OP_WRITE_LATCH_SET}, 8);
        send(w >> (16 - r.nb), r.nb + 8);
        for (int i = 0; i < 10 && busy_o !== 1'b1; i++) tick(1);
        for (int i = 0; i < 200 && busy_o === 1'b1; i++) begin
            n++;
            tick(1);
        end
        tick(4);
        check_word(16'(n), r.acc ? 16'(WC) : 16'h0000, "busy span");
        check_word(st() & 16'hfffc, r.ex, "status");
        check_bit(write_latch_o, r.lat & !r.acc, "latch");
    endtask

    initial begin
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        tick(4);
        foreach (rows[i]) step(rows[i]);
        send({48'h0, sfsr_pkg::OP_STATUS_READ_HIGH, 8'h00}, 16);
        check_word({8'h00, rx[7:0]}, 16'h0009, "high status read");
        send({48'h0, sfsr_pkg::OP_STATUS_READ_LOW, 8'h00}, 16);
        check_word({8'h00, rx[7:0]}, 16'h0006, "low status read");
        do_reset();
        check_word(st(), 16'h0804, "power cycle");
        @(posedge clock_i) array_wr_en_i <= 1'b1;
        array_wr_addr_i <= 16'hffff;
        array_wr_data_i <= 8'h5a;
        @(posedge clock_i) array_wr_addr_i <= 16'h0000;
        array_wr_data_i <= 8'ha5;
        @(posedge clock_i) array_wr_en_i <= 1'b0;
        send({16'h0, sfsr_pkg::OP_READ, 24'h00ffff, 16'h0}, 48);
        check_word(rx[15:0], 16'h5aa5, "read wrap");
        send({8'h0, sfsr_pkg::OP_FAST_READ, 24'h00ffff, 8'h00, 16'h0}, 56);
        check_word(rx[15:0], 16'h5aa5, "fast read wrap");
        send({56'h0, sfsr_pkg::OP_WRITE_LATCH_SET}, 8);
        send({40'h0, sfsr_pkg::OP_STATUS_WRITE, 16'h0408}, 24);
        tick(4);
        check_bit(busy_o, 1'b1, "cycle started");
        send({8'h0, sfsr_pkg::OP_FAST_READ, 24'h00ffff, 8'h00, 16'h0}, 56);
        check_bit(drv, 1'b0, "fast read in cycle");
        host.frame({56'h0, sfsr_pkg::OP_BUSY_MONITOR}, 8, 1'b1, rx, drv);
        #20;
        check_bit(so_oe_n_o, 1'b0, "monitor drive");
        check_bit(so_o, 1'b1, "monitor busy");
        for (int i = 0; i < 200 && busy_o === 1'b1; i++) tick(1);
        #20;
        check_bit(so_o, 1'b0, "monitor done");
        host.end_frame();
        #5;
        check_bit(so_oe_n_o, 1'b1, "monitor end");
        check_word(st(), 16'h0804, "after cycle");
        for (int i = 0; i < 2; i++) begin
            @(posedge clock_i) ext_op_busy_i <= 1'b1;
            ext_op_is_erase_i <= (i == 0);
            tick(3);
            check_bit(busy_o, 1'b1, "engine busy");
            send({56'h0, i ? sfsr_pkg::OP_SUSPEND_B : sfsr_pkg::OP_SUSPEND_A}, 8);
            tick(4);
            check_word(st(), i ? 16'h0c04 : 16'h8804, "suspended");
            send({56'h0, i ? sfsr_pkg::OP_RESUME_B : sfsr_pkg::OP_RESUME_A}, 8);
            tick(4);
            check_word(st(), 16'h0805, "resumed");
            @(posedge clock_i) ext_op_busy_i <= 1'b0;
            tick(3);
        end
        step(sfsr_row_s'{1'b1, 1'b1, 5'h10, 16'h0180, 1'b1, 16'h0980});
        step(sfsr_row_s'{1'b1, 1'b1, 5'h10, 16'h0000, 1'b0, 16'h0980});
        do_reset();
        check_word(st(), 16'h0980, "one-time mode");
        give_verdict();
    end
endmodule

`default_nettype wire
